// [logic/sdbp_top.sv]
`timescale 1ns/100ps
// Summary of operation
// - rx buffer A start address, 13 bits
// - rx buffer A end address, 13 bits
// - rx buffer B start and end addresses
// - tx buffer A start, reads begin there
// - tx buffer A end, last byte taken
// - tx buffer B start and end addresses
// - capture first error offset, rx buffer A
// - capture first error offset, rx buffer B
// - no error captured reads as zero
// - later errors leave captured offset unchanged
// - re-arm only on reload or rx reset
// - fill offset advances, wraps to zero
module sdbp_top import sdbp_pkg::*; (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // register port
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // buffer load requests
  input wire logic rx_load_a_in,
  input wire logic rx_load_b_in,
  input wire logic tx_load_a_in,
  input wire logic tx_load_b_in,
  // receive bytes from the shift logic
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_byte_err_in,
  // transmit bytes to the shift logic
  input wire logic tx_byte_req_in,
  output logic [7:0] tx_byte_out,
  output logic tx_byte_valid_out,
  // ram port
  output logic [12:0] ram_addr_out,
  output logic [7:0] ram_wdata_out,
  output logic ram_we_out,
  output logic ram_re_out,
  input wire logic [7:0] ram_rdata_in,
  // interrupt
  output logic irq_out
);
  logic [12:0] buf_r [8];
  logic [12:0] rx_buffer_a_first_error_r;
  logic [12:0] rx_buffer_b_first_error_r;
  logic seen_a_r;
  logic seen_b_r;
  logic [6:0] stat_r;
  logic [6:0] stat_nxt;
  logic [6:0] mask_r;
  logic [6:0] mask_nxt;
  logic [6:0] ev_w;
  logic irq_r;
  logic [15:0] rdata_r;
  logic [15:0] rd_val_w;
  logic [12:0] ram_addr_r;
  logic [7:0] ram_wdata_r;
  logic ram_we_r;
  logic ram_re_r;
  sdbp_tx_st_t tx_st_r;
  logic tx_pend_r;
  logic [7:0] tx_byte_r;
  logic tx_valid_r;
  logic [3:0] wr_ix_w;
  logic [3:0] rd_ix_w;
  logic rx_go_w;
  logic tx_go_w;
  logic err_a_w;
  logic err_b_w;
  logic ctl_wr_w;
  logic stat_wr_w;

  sdbp_chan_if rx_ch ();
  sdbp_chan_if tx_ch ();

  // bit 3 flags a hit, bits 2..0 are the register index
  function automatic logic [3:0] sdbp_buf_ix(input logic [15:0] a);
    case (a)
      SDBP_OFF_RX_A_START: return {1'b1, SDBP_IX_RX_A_START};
      SDBP_OFF_RX_A_END: return {1'b1, SDBP_IX_RX_A_END};
      SDBP_OFF_RX_B_START: return {1'b1, SDBP_IX_RX_B_START};
      SDBP_OFF_RX_B_END: return {1'b1, SDBP_IX_RX_B_END};
      SDBP_OFF_TX_A_START: return {1'b1, SDBP_IX_TX_A_START};
      SDBP_OFF_TX_A_END: return {1'b1, SDBP_IX_TX_A_END};
      SDBP_OFF_TX_B_START: return {1'b1, SDBP_IX_TX_B_START};
      SDBP_OFF_TX_B_END: return {1'b1, SDBP_IX_TX_B_END};
      default: return 4'h0;
    endcase
  endfunction : sdbp_buf_ix

  assign wr_ix_w = sdbp_buf_ix(reg_addr_in);
  assign rd_ix_w = sdbp_buf_ix(reg_addr_in);
  assign ctl_wr_w = reg_wr_in && (reg_addr_in == SDBP_OFF_DMA_CTRL);
  assign stat_wr_w = reg_wr_in && (reg_addr_in == SDBP_OFF_IRQ_STAT);

  // only the 13-bit field is stored, the fixed top bits are not
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (int i = 0; i < 8; i++) begin
        buf_r[i] <= SDBP_ADDR_RST;
      end
    end else if (ce_in && reg_wr_in && wr_ix_w[3]) begin
      buf_r[wr_ix_w[2:0]] <= reg_wdata_in[12:0];
    end
  end

  // receive channel
  assign rx_ch.start_a = buf_r[SDBP_IX_RX_A_START];
  assign rx_ch.end_a = buf_r[SDBP_IX_RX_A_END];
  assign rx_ch.start_b = buf_r[SDBP_IX_RX_B_START];
  assign rx_ch.end_b = buf_r[SDBP_IX_RX_B_END];
  assign rx_ch.load_a = rx_load_a_in;
  assign rx_ch.load_b = rx_load_b_in;
  assign rx_ch.xfer = rx_go_w;
  assign rx_ch.dma_rst = ctl_wr_w && reg_wdata_in[SDBP_CTL_RX_RST];

  // transmit channel
  assign tx_ch.start_a = buf_r[SDBP_IX_TX_A_START];
  assign tx_ch.end_a = buf_r[SDBP_IX_TX_A_END];
  assign tx_ch.start_b = buf_r[SDBP_IX_TX_B_START];
  assign tx_ch.end_b = buf_r[SDBP_IX_TX_B_END];
  assign tx_ch.load_a = tx_load_a_in;
  assign tx_ch.load_b = tx_load_b_in;
  assign tx_ch.xfer = tx_go_w;
  assign tx_ch.dma_rst = ctl_wr_w && reg_wdata_in[SDBP_CTL_TX_RST];

  sdbp_chan u_rx_chan (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .ch(rx_ch)
  );

  sdbp_chan u_tx_chan (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .ch(tx_ch)
  );

  // a byte with no loaded buffer is dropped and flagged as overrun
  assign rx_go_w = rx_byte_valid_in && rx_ch.ready;
  // receive owns the ram port; a transmit fetch waits for a cycle with no receive byte
  assign tx_go_w = (tx_st_r == SDBP_TX_IDLE) && tx_pend_r && tx_ch.ready && !rx_go_w;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ram_addr_r <= SDBP_ADDR_RST;
      ram_wdata_r <= 8'h00;
      ram_we_r <= 1'b0;
      ram_re_r <= 1'b0;
    end else if (ce_in) begin
      ram_we_r <= rx_go_w;
      ram_re_r <= tx_go_w;
      if (rx_go_w) begin
        ram_addr_r <= rx_ch.addr;
        ram_wdata_r <= rx_byte_in;
      end else if (tx_go_w) begin
        ram_addr_r <= tx_ch.addr;
      end
    end
  end

  // a new request in the issue cycle is kept, not lost
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      tx_pend_r <= 1'b0;
    end else if (ce_in) begin
      tx_pend_r <= tx_byte_req_in || (tx_pend_r && !tx_go_w);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      tx_st_r <= SDBP_TX_IDLE;
    end else if (ce_in) begin
      case (tx_st_r)
        SDBP_TX_IDLE: begin
          if (tx_go_w) begin
            tx_st_r <= SDBP_TX_ISSUE;
          end
        end
        SDBP_TX_ISSUE: begin
          tx_st_r <= SDBP_TX_TAKE;
        end
        SDBP_TX_TAKE: begin
          tx_st_r <= SDBP_TX_IDLE;
        end
        default: begin
          tx_st_r <= SDBP_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      tx_byte_r <= 8'h00;
      tx_valid_r <= 1'b0;
    end else if (ce_in) begin
      tx_valid_r <= (tx_st_r == SDBP_TX_TAKE);
      if (tx_st_r == SDBP_TX_TAKE) begin
        tx_byte_r <= ram_rdata_in;
      end
    end
  end

  // first error capture, one per receive buffer
  assign err_a_w = rx_go_w && rx_byte_err_in && !rx_ch.act_b && !seen_a_r;
  assign err_b_w = rx_go_w && rx_byte_err_in && rx_ch.act_b && !seen_b_r;

  // a load of an unloaded buffer is the only re-arm besides rx reset
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      seen_a_r <= 1'b0;
      rx_buffer_a_first_error_r <= SDBP_ERR_RST;
    end else if (ce_in) begin
      if (rx_ch.dma_rst || (rx_load_a_in && !rx_ch.loaded_a)) begin
        seen_a_r <= 1'b0;
        rx_buffer_a_first_error_r <= SDBP_ERR_RST;
      end else if (err_a_w) begin
        seen_a_r <= 1'b1;
        rx_buffer_a_first_error_r <= rx_ch.offs;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      seen_b_r <= 1'b0;
      rx_buffer_b_first_error_r <= SDBP_ERR_RST;
    end else if (ce_in) begin
      if (rx_ch.dma_rst || (rx_load_b_in && !rx_ch.loaded_b)) begin
        seen_b_r <= 1'b0;
        rx_buffer_b_first_error_r <= SDBP_ERR_RST;
      end else if (err_b_w) begin
        seen_b_r <= 1'b1;
        rx_buffer_b_first_error_r <= rx_ch.offs;
      end
    end
  end

  // interrupt status: write one to clear, a new event wins over the clear
  always_comb begin
    ev_w = SDBP_IRQ_RST;
    ev_w[SDBP_EV_RX_ULD_A] = rx_ch.uld_a;
    ev_w[SDBP_EV_RX_ULD_B] = rx_ch.uld_b;
    ev_w[SDBP_EV_TX_ULD_A] = tx_ch.uld_a;
    ev_w[SDBP_EV_TX_ULD_B] = tx_ch.uld_b;
    ev_w[SDBP_EV_RX_ERR_A] = err_a_w;
    ev_w[SDBP_EV_RX_ERR_B] = err_b_w;
    ev_w[SDBP_EV_RX_OVF] = rx_byte_valid_in && !rx_ch.ready;
    stat_nxt = (stat_r & ~(stat_wr_w ? reg_wdata_in[6:0] : SDBP_IRQ_RST)) | ev_w;
    mask_nxt = mask_r;
    if (reg_wr_in && (reg_addr_in == SDBP_OFF_IRQ_MASK)) begin
      mask_nxt = reg_wdata_in[6:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      stat_r <= SDBP_IRQ_RST;
      mask_r <= SDBP_IRQ_RST;
      irq_r <= 1'b0;
    end else if (ce_in) begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_val_w = 16'h0000;
    if (rd_ix_w[3]) begin
      rd_val_w = {SDBP_ADDR_FIXED, buf_r[rd_ix_w[2:0]]};
    end else begin
      case (reg_addr_in)
        SDBP_OFF_RX_A_ERR: rd_val_w = {3'h0, rx_buffer_a_first_error_r};
        SDBP_OFF_RX_B_ERR: rd_val_w = {3'h0, rx_buffer_b_first_error_r};
        SDBP_OFF_IRQ_STAT: rd_val_w = {9'h000, stat_r};
        SDBP_OFF_IRQ_MASK: rd_val_w = {9'h000, mask_r};
        SDBP_OFF_DMA_STATE: begin
          rd_val_w = {10'h000, tx_ch.loaded_b, tx_ch.loaded_a, rx_ch.loaded_b,
                      rx_ch.loaded_a, tx_ch.act_b, rx_ch.act_b};
        end
        default: rd_val_w = 16'h0000;
      endcase
    end
  end

  // read data stand for exactly one cycle, zero otherwise
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rdata_r <= 16'h0000;
    end else if (ce_in) begin
      rdata_r <= reg_rd_in ? rd_val_w : 16'h0000;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign tx_byte_out = tx_byte_r;
  assign tx_byte_valid_out = tx_valid_r;
  assign ram_addr_out = ram_addr_r;
  assign ram_wdata_out = ram_wdata_r;
  assign ram_we_out = ram_we_r;
  assign ram_re_out = ram_re_r;
  assign irq_out = irq_r;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  property p_rx_a_start;
    ce_in && reg_wr_in && reg_addr_in == SDBP_OFF_RX_A_START
      ##1 ce_in && reg_rd_in && reg_addr_in == SDBP_OFF_RX_A_START
      |=> reg_rdata_out[12:0] == $past(reg_wdata_in[12:0], 2);
  endproperty
  a_rx_a_start: assert property (p_rx_a_start)
    else $error("rx buffer A start did not read back");

  property p_buf_rdback;
    ce_in && reg_wr_in && wr_ix_w[3]
      ##1 ce_in && reg_rd_in && reg_addr_in == $past(reg_addr_in)
      |=> reg_rdata_out[12:0] == $past(reg_wdata_in[12:0], 2);
  endproperty
  a_buf_rdback: assert property (p_buf_rdback)
    else $error("address register did not read back");

  property p_fixed_bits;
    ce_in && reg_rd_in && rd_ix_w[3] |=> reg_rdata_out[15:13] == 3'b011;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("fixed bits of address register wrong");

  property p_tx_first;
    ce_in && tx_go_w && tx_ch.offs == 13'h0000 && !tx_ch.act_b
      |=> ram_re_out && ram_addr_out == $past(tx_ch.start_a) ##2 tx_byte_valid_out;
  endproperty
  a_tx_first: assert property (p_tx_first)
    else $error("transmit did not start at buffer A start");

  property p_err_a_cap;
    ce_in && err_a_w ##1 ce_in && reg_rd_in && reg_addr_in == SDBP_OFF_RX_A_ERR
      |=> reg_rdata_out == {3'h0, $past(rx_ch.offs, 2)};
  endproperty
  a_err_a_cap: assert property (p_err_a_cap)
    else $error("rx buffer A error offset not captured");

  property p_err_b_cap;
    ce_in && err_b_w |=> seen_b_r && rx_buffer_b_first_error_r == $past(rx_ch.offs);
  endproperty
  a_err_b_cap: assert property (p_err_b_cap)
    else $error("rx buffer B error offset not captured");

  property p_no_err_zero;
    ce_in && reg_rd_in && reg_addr_in == SDBP_OFF_RX_A_ERR && !seen_a_r
      |=> reg_rdata_out == 16'h0000;
  endproperty
  a_no_err_zero: assert property (p_no_err_zero)
    else $error("error offset nonzero with no error captured");

  property p_err_hold;
    seen_a_r && !rx_load_a_in && !rx_ch.dma_rst |=> $stable(rx_buffer_a_first_error_r);
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("captured error offset changed");

  property p_rearm;
    $fell(seen_b_r) |-> $past(rx_load_b_in) || $past(rx_ch.dma_rst);
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("error capture re-armed without reload or reset");
endmodule : sdbp_top

// [inc/sdbp_pkg.sv]
package sdbp_pkg;
  // buffer address and offset width
  localparam int unsigned SDBP_AW = 13;
  // register offsets, byte addresses
  localparam logic [15:0] SDBP_OFF_RX_A_START = 16'h4480;
  localparam logic [15:0] SDBP_OFF_RX_A_END = 16'h4482;
  localparam logic [15:0] SDBP_OFF_RX_B_START = 16'h4484;
  localparam logic [15:0] SDBP_OFF_RX_B_END = 16'h4486;
  localparam logic [15:0] SDBP_OFF_TX_A_START = 16'h4488;
  localparam logic [15:0] SDBP_OFF_TX_A_END = 16'h448A;
  localparam logic [15:0] SDBP_OFF_TX_B_START = 16'h448C;
  localparam logic [15:0] SDBP_OFF_TX_B_END = 16'h448E;
  localparam logic [15:0] SDBP_OFF_RX_A_ERR = 16'h449A;
  localparam logic [15:0] SDBP_OFF_RX_B_ERR = 16'h449C;
  localparam logic [15:0] SDBP_OFF_IRQ_STAT = 16'h44A0;
  localparam logic [15:0] SDBP_OFF_IRQ_MASK = 16'h44A2;
  localparam logic [15:0] SDBP_OFF_DMA_STATE = 16'h44A4;
  localparam logic [15:0] SDBP_OFF_DMA_CTRL = 16'h44A6;
  // index of each address register in the register array
  localparam logic [2:0] SDBP_IX_RX_A_START = 3'h0;
  localparam logic [2:0] SDBP_IX_RX_A_END = 3'h1;
  localparam logic [2:0] SDBP_IX_RX_B_START = 3'h2;
  localparam logic [2:0] SDBP_IX_RX_B_END = 3'h3;
  localparam logic [2:0] SDBP_IX_TX_A_START = 3'h4;
  localparam logic [2:0] SDBP_IX_TX_A_END = 3'h5;
  localparam logic [2:0] SDBP_IX_TX_B_START = 3'h6;
  localparam logic [2:0] SDBP_IX_TX_B_END = 3'h7;
  // fixed upper bits of an address register, bits 15..13
  localparam logic [2:0] SDBP_ADDR_FIXED = 3'h3;
  localparam logic [12:0] SDBP_ADDR_RST = 13'h0000;
  localparam logic [12:0] SDBP_ERR_RST = 13'h0000;
  // interrupt status and mask bit positions
  localparam int unsigned SDBP_EV_RX_ULD_A = 0;
  localparam int unsigned SDBP_EV_RX_ULD_B = 1;
  localparam int unsigned SDBP_EV_TX_ULD_A = 2;
  localparam int unsigned SDBP_EV_TX_ULD_B = 3;
  localparam int unsigned SDBP_EV_RX_ERR_A = 4;
  localparam int unsigned SDBP_EV_RX_ERR_B = 5;
  localparam int unsigned SDBP_EV_RX_OVF = 6;
  localparam int unsigned SDBP_EV_N = 7;
  localparam logic [6:0] SDBP_IRQ_RST = 7'h00;
  // dma control bits, write-one pulses
  localparam int unsigned SDBP_CTL_RX_RST = 0;
  localparam int unsigned SDBP_CTL_TX_RST = 1;
  typedef enum logic [1:0] {SDBP_TX_IDLE, SDBP_TX_ISSUE, SDBP_TX_TAKE} sdbp_tx_st_t;
endpackage : sdbp_pkg

// [inc/sdbp_chan_if.sv]
`timescale 1ns/100ps
interface sdbp_chan_if;
  logic [12:0] start_a;
  logic [12:0] end_a;
  logic [12:0] start_b;
  logic [12:0] end_b;
  logic load_a;
  logic load_b;
  logic xfer;
  logic dma_rst;
  logic ready;
  logic act_b;
  logic [12:0] offs;
  logic [12:0] addr;
  logic uld_a;
  logic uld_b;
  logic loaded_a;
  logic loaded_b;
  modport eng (
    input start_a, end_a, start_b, end_b, load_a, load_b, xfer, dma_rst,
    output ready, act_b, offs, addr, uld_a, uld_b, loaded_a, loaded_b
  );
  modport ctl (
    output start_a, end_a, start_b, end_b, load_a, load_b, xfer, dma_rst,
    input ready, act_b, offs, addr, uld_a, uld_b, loaded_a, loaded_b
  );
endinterface : sdbp_chan_if

// [logic/sdbp_chan.sv]
`timescale 1ns/100ps
module sdbp_chan import sdbp_pkg::*; (
  // clock and control
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // channel view
  sdbp_chan_if.eng ch
);
  logic [12:0] offs_r;
  logic ld_a_r;
  logic ld_b_r;
  logic act_b_r;
  logic [12:0] end_w;
  logic ld_act_w;
  logic at_end_w;
  logic step_w;

  assign end_w = act_b_r ? ch.end_b : ch.end_a;
  assign ld_act_w = act_b_r ? ld_b_r : ld_a_r;
  assign ch.addr = (act_b_r ? ch.start_b : ch.start_a) + offs_r;
  assign at_end_w = (ch.addr == end_w);
  assign step_w = ch.xfer && ld_act_w;
  assign ch.ready = ld_act_w;
  assign ch.act_b = act_b_r;
  assign ch.offs = offs_r;
  assign ch.uld_a = step_w && at_end_w && !act_b_r;
  assign ch.uld_b = step_w && at_end_w && act_b_r;
  assign ch.loaded_a = ld_a_r;
  assign ch.loaded_b = ld_b_r;

  // a load in the same cycle as an unload of that buffer wins
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ld_a_r <= 1'b0;
      ld_b_r <= 1'b0;
    end else if (ce_in) begin
      if (ch.dma_rst) begin
        ld_a_r <= 1'b0;
        ld_b_r <= 1'b0;
      end else begin
        ld_a_r <= ch.load_a || (ld_a_r && !ch.uld_a);
        ld_b_r <= ch.load_b || (ld_b_r && !ch.uld_b);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      offs_r <= SDBP_ADDR_RST;
    end else if (ce_in) begin
      if (ch.dma_rst) begin
        offs_r <= SDBP_ADDR_RST;
      end else if (step_w) begin
        offs_r <= at_end_w ? SDBP_ADDR_RST : offs_r + 13'h0001;
      end
    end
  end

  // ping-pong: after an unload move on; an idle side yields to a loaded one
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      act_b_r <= 1'b0;
    end else if (ce_in) begin
      if (ch.dma_rst) begin
        act_b_r <= 1'b0;
      end else if (step_w && at_end_w) begin
        act_b_r <= !act_b_r;
      end else if (!ld_act_w && (act_b_r ? ld_a_r : ld_b_r)) begin
        act_b_r <= !act_b_r;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  property p_wrap_zero;
    ce_in && (ch.uld_a || ch.uld_b) |=> offs_r == 13'h0000;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("offset did not return to zero after unload");

  property p_span_end;
    ce_in && step_w && !at_end_w && !ch.dma_rst |=> ld_act_w && offs_r == $past(offs_r) + 13'h0001;
  endproperty
  a_span_end: assert property (p_span_end)
    else $error("buffer ended before its end address");
endmodule : sdbp_chan

// [verification/sdbp_ram_model.sv]
`timescale 1ns/100ps
module sdbp_ram_model (
  // clock
  input wire logic clk_sys_in,
  // ram port seen from the engine
  input wire logic [12:0] ram_addr_in,
  input wire logic [7:0] ram_wdata_in,
  input wire logic ram_we_in,
  input wire logic ram_re_in,
  output logic [7:0] ram_rdata_out
);
  logic [7:0] mem_r [0:8191];
  initial ram_rdata_out = 8'h5A;
  // off-cycle data toggles so a sample one cycle late never matches by luck
  always @(posedge clk_sys_in) begin
    if (ram_we_in)
      mem_r[ram_addr_in] <= ram_wdata_in;
    if (ram_re_in)
      ram_rdata_out <= mem_r[ram_addr_in];
    else
      ram_rdata_out <= ~ram_rdata_out;
  end
endmodule : sdbp_ram_model

// [verification/sdbp_top_tb.sv]
`timescale 1ns/100ps
module sdbp_top_tb;
  import sdbp_pkg::*;
  logic clk_sys_in, srst_in, ce_in, reg_wr_in, reg_rd_in;
  logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic rx_load_a_in, rx_load_b_in, tx_load_a_in, tx_load_b_in;
  logic rx_byte_valid_in, rx_byte_err_in, tx_byte_req_in, tx_byte_valid_out;
  logic [7:0] rx_byte_in, tx_byte_out, ram_wdata_out, ram_rdata_in;
  logic [12:0] ram_addr_out;
  logic ram_we_out, ram_re_out, irq_out;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [15:0] offs [8] = '{SDBP_OFF_RX_A_START, SDBP_OFF_RX_A_END, SDBP_OFF_RX_B_START,
    SDBP_OFF_RX_B_END, SDBP_OFF_TX_A_START, SDBP_OFF_TX_A_END, SDBP_OFF_TX_B_START,
    SDBP_OFF_TX_B_END};

  sdbp_top uut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_load_a_in(rx_load_a_in),
    .rx_load_b_in(rx_load_b_in), .tx_load_a_in(tx_load_a_in), .tx_load_b_in(tx_load_b_in),
    .rx_byte_valid_in(rx_byte_valid_in), .rx_byte_in(rx_byte_in),
    .rx_byte_err_in(rx_byte_err_in), .tx_byte_req_in(tx_byte_req_in),
    .tx_byte_out(tx_byte_out), .tx_byte_valid_out(tx_byte_valid_out),
    .ram_addr_out(ram_addr_out), .ram_wdata_out(ram_wdata_out), .ram_we_out(ram_we_out),
    .ram_re_out(ram_re_out), .ram_rdata_in(ram_rdata_in), .irq_out(irq_out));

  sdbp_ram_model ram (.clk_sys_in(clk_sys_in), .ram_addr_in(ram_addr_out),
    .ram_wdata_in(ram_wdata_out), .ram_we_in(ram_we_out), .ram_re_in(ram_re_out),
    .ram_rdata_out(ram_rdata_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // a hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask : rdc

  task automatic load(input int k);
    @(posedge clk_sys_in);
    rx_load_a_in <= (k == 0);
    rx_load_b_in <= (k == 1);
    tx_load_a_in <= (k == 2);
    @(posedge clk_sys_in);
    rx_load_a_in <= 1'b0;
    rx_load_b_in <= 1'b0;
    tx_load_a_in <= 1'b0;
  endtask : load

  task automatic rx_byte(input logic [7:0] d, input logic err, input logic we,
                         input logic [12:0] a);
    @(posedge clk_sys_in);
    rx_byte_valid_in <= 1'b1;
    rx_byte_in <= d;
    rx_byte_err_in <= err;
    @(posedge clk_sys_in);
    rx_byte_valid_in <= 1'b0;
    rx_byte_err_in <= 1'b0;
    #1;
    chk({15'h0000, ram_we_out}, {15'h0000, we});
    if (we) begin
      chk({3'h0, ram_addr_out}, {3'h0, a});
      chk({8'h00, ram_wdata_out}, {8'h00, d});
    end
  endtask : rx_byte

  task automatic tx_get(input logic [7:0] exp, input logic [12:0] a);
    int n;
    @(posedge clk_sys_in);
    tx_byte_req_in <= 1'b1;
    @(posedge clk_sys_in);
    tx_byte_req_in <= 1'b0;
    for (n = 0; n < 10; n++) begin
      @(posedge clk_sys_in);
      #1;
      // with no receive traffic the fetch starts at once
      if (n == 0) begin
        chk({15'h0000, ram_re_out}, 16'h0001);
        chk({3'h0, ram_addr_out}, {3'h0, a});
      end
      if (tx_byte_valid_out === 1'b1)
        break;
    end
    chk(16'(n < 10), 16'h0001);
    chk({8'h00, tx_byte_out}, {8'h00, exp});
  endtask : tx_get

  task automatic t_reset();
    for (int i = 0; i < 8; i++)
      rdc(offs[i], 16'h6000);
    rdc(SDBP_OFF_RX_A_ERR, 16'h0000);
    rdc(SDBP_OFF_RX_B_ERR, 16'h0000);
    rdc(16'h44FE, 16'h0000);
  endtask : t_reset

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      wr(offs[i], 16'hFFFF);
      rdc(offs[i], 16'h7FFF);
      wr(offs[i], 16'h9000 + 16'(i));
      rdc(offs[i], 16'h7000 + 16'(i));
    end
    wr(SDBP_OFF_RX_A_ERR, 16'h1234);
    rdc(SDBP_OFF_RX_A_ERR, 16'h0000);
    // a write while the clock enable is low must be lost
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    wr(offs[1], 16'h0055);
    ce_in <= 1'b1;
    rdc(offs[1], 16'h7001);
  endtask : t_regs

  task automatic t_rx();
    wr(SDBP_OFF_RX_A_START, 16'h0100);
    wr(SDBP_OFF_RX_A_END, 16'h0103);
    wr(SDBP_OFF_RX_B_START, 16'h0200);
    wr(SDBP_OFF_RX_B_END, 16'h0201);
    load(0);
    load(1);
    for (int i = 0; i < 4; i++)
      rx_byte(8'hA0 + 8'(i), i >= 2, 1'b1, 13'h0100 + 13'(i));
    rdc(SDBP_OFF_RX_A_ERR, 16'h0002);
    rx_byte(8'hB0, 1'b0, 1'b1, 13'h0200);
    rx_byte(8'hB1, 1'b1, 1'b1, 13'h0201);
    rdc(SDBP_OFF_RX_B_ERR, 16'h0001);
    // both buffers unloaded: byte must be dropped
    rx_byte(8'hC0, 1'b1, 1'b0, 13'h0000);
    rdc(SDBP_OFF_RX_B_ERR, 16'h0001);
    rdc(SDBP_OFF_IRQ_STAT, 16'h0073);
    chk({15'h0000, irq_out}, 16'h0000);
    wr(SDBP_OFF_IRQ_MASK, 16'h0001);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk({15'h0000, irq_out}, 16'h0001);
    wr(SDBP_OFF_IRQ_STAT, 16'h007F);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk({15'h0000, irq_out}, 16'h0000);
  endtask : t_rx

  task automatic t_tx();
    wr(SDBP_OFF_TX_A_START, 16'h0101);
    wr(SDBP_OFF_TX_A_END, 16'h0102);
    load(2);
    tx_get(8'hA1, 13'h0101);
    tx_get(8'hA2, 13'h0102);
    rdc(SDBP_OFF_IRQ_STAT, 16'h0004);
  endtask : t_tx

  task automatic t_rearm();
    load(0);
    rx_byte(8'h11, 1'b0, 1'b1, 13'h0100);
    rx_byte(8'h22, 1'b1, 1'b1, 13'h0101);
    rdc(SDBP_OFF_RX_A_ERR, 16'h0001);
    rdc(SDBP_OFF_RX_B_ERR, 16'h0001);
    load(1);
    rdc(SDBP_OFF_RX_B_ERR, 16'h0000);
    wr(SDBP_OFF_DMA_CTRL, 16'h0001);
    rdc(SDBP_OFF_RX_A_ERR, 16'h0000);
  endtask : t_rearm

  // strobes with no idle cycle between them
  task automatic t_b2b();
    load(0);
    rx_byte(8'h33, 1'b0, 1'b1, 13'h0100);
    @(posedge clk_sys_in);
    rx_byte_valid_in <= 1'b1;
    rx_byte_in <= 8'h44;
    rx_byte_err_in <= 1'b1;
    @(posedge clk_sys_in);
    rx_byte_valid_in <= 1'b0;
    rx_byte_err_in <= 1'b0;
    reg_rd_in <= 1'b1;
    reg_addr_in <= SDBP_OFF_RX_A_ERR;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, 16'h0001);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= SDBP_OFF_RX_A_START;
    reg_wdata_in <= 16'hE100;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, 16'h6100);
  endtask : t_b2b

  initial begin
    srst_in = 1'b1;
    ce_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 16'h0000;
    reg_wdata_in = 16'h0000;
    rx_load_a_in = 1'b0;
    rx_load_b_in = 1'b0;
    tx_load_a_in = 1'b0;
    tx_load_b_in = 1'b0;
    rx_byte_valid_in = 1'b0;
    rx_byte_in = 8'h00;
    rx_byte_err_in = 1'b0;
    tx_byte_req_in = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    t_reset();
    t_regs();
    t_rx();
    t_tx();
    t_rearm();
    t_b2b();
    tally_and_finish();
  end
endmodule : sdbp_top_tb
